// *** port_pin_configuration.sv ***
// pin configuration and routing for all parallel ports, AXI4-Lite registers
//
// How it works
// - each pin has its own three configuration bits in bit planes
// - any pin can be bidirectional or input-only
// - threshold pins use config bit two to pick TTL or CMOS levels
// - hysteresis pins ignore the threshold selection
// - open drain only turns off the high-side driver
// - pure open-drain pins never push high and have no pull-up
// - pull-ups only where the pin has one built in
// - reset mode per pin: bidirectional, bidirectional with pull-up, input
// - ports zero and one carry the external memory bus
// - peripheral inputs see the pin in every digital mode, whenever the peripheral is on
// - analog inputs connect only on explicit selection
// - peripheral outputs drive only after explicit selection
// - bits 1,0,1 give input for a peripheral on a hysteresis pin
// - bits 0,1,1 give peripheral push-pull output
// - bits 1,1,1 give the bidirectional memory bus function
// - bits 1,1,1 on analog pins connect the converter input
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps

module port_pin_configuration #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic                                 aclk,
   input  wire logic                                 aresetn,
   // axi4-lite write address and data
   input  wire logic                                 s_axi_awvalid,
   output      logic                                 s_axi_awready,
   input  wire logic [ADDR_W-1:0]                    s_axi_awaddr,
   input  wire logic [2:0]                           s_axi_awprot,
   input  wire logic                                 s_axi_wvalid,
   output      logic                                 s_axi_wready,
   input  wire logic [31:0]                          s_axi_wdata,
   input  wire logic [3:0]                           s_axi_wstrb,
   // axi4-lite write response
   output      logic                                 s_axi_bvalid,
   input  wire logic                                 s_axi_bready,
   output      logic [1:0]                           s_axi_bresp,
   // axi4-lite read
   input  wire logic                                 s_axi_arvalid,
   output      logic                                 s_axi_arready,
   input  wire logic [ADDR_W-1:0]                    s_axi_araddr,
   input  wire logic [2:0]                           s_axi_arprot,
   output      logic                                 s_axi_rvalid,
   input  wire logic                                 s_axi_rready,
   output      logic [31:0]                          s_axi_rdata,
   output      logic [1:0]                           s_axi_rresp,
   // pads
   input  wire logic [port_cfg_pkg::PIN_COUNT-1:0]   pad_in,
   output      logic [port_cfg_pkg::PIN_COUNT-1:0]   pad_out,
   output      logic [port_cfg_pkg::PIN_COUNT-1:0]   pad_oe,
   output      logic [port_cfg_pkg::PIN_COUNT-1:0]   weak_pullup,
   output      logic [port_cfg_pkg::PIN_COUNT-1:0]   cmos_level_sel,
   output      logic [port_cfg_pkg::PIN_COUNT-1:0]   analog_connect,
   // external memory bus, ports zero and one
   input  wire logic [7:0]                           mem_addr_data_out,
   input  wire logic                                 mem_addr_data_oe,
   input  wire logic [7:0]                           mem_addr_high,
   // on-chip peripherals, outputs on ports two and up, inputs on every pin
   input  wire logic [port_cfg_pkg::PIN_COUNT-17:0]  peripheral_function_out,
   input  wire logic [port_cfg_pkg::PIN_COUNT-17:0]  peripheral_function_oe,
   output      logic [port_cfg_pkg::PIN_COUNT-1:0]   peripheral_function_in
);

   localparam int NP = port_cfg_pkg::PIN_COUNT;

   ////////////////////////////////////////////////////////////////////////////
   // configuration planes
   logic [NP-1:0] pin_cfg_bit_two;
   logic [NP-1:0] pin_cfg_bit_one;
   logic [NP-1:0] pin_cfg_bit_zero;
   logic [NP-1:0] data_out;
   logic [NP-1:0] pin_level;

   // write channel state
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0]        w_byte;
   logic              w_lane0;

   // decode: returns {valid, port index, register index}
   function automatic logic [8:0] decode_addr(input logic [ADDR_W-1:0] a);
      logic [3:0] port_idx;
      logic [2:0] reg_idx;
      logic       ok;
      port_idx = a[port_cfg_pkg::PORT_SHIFT +: 4];
      reg_idx  = a[port_cfg_pkg::WORD_SHIFT +: 3];
      ok = (32'(port_idx) < port_cfg_pkg::PORT_COUNT)
         && (reg_idx <= port_cfg_pkg::REG_PIN_LVL[2:0])
         && (a[1:0] == 2'h0)
         && ((a >> (port_cfg_pkg::PORT_SHIFT + 4)) == '0);
      return {ok, port_idx, reg_idx, 1'b0};
   endfunction : decode_addr

   // pin mode from its three bits and its traits
   function automatic port_cfg_pkg::pin_mode_t pin_mode(
      input logic c2, input logic c1, input logic c0, input logic analog);
      port_cfg_pkg::pin_mode_t m;
      case ({c1, c0})
         2'b00:   m = port_cfg_pkg::MODE_BIDIR_OD;
         2'b01:   m = port_cfg_pkg::MODE_INPUT;
         2'b10:   m = c2 ? port_cfg_pkg::MODE_OUT_OD
                         : port_cfg_pkg::MODE_OUT_PP;
         default: begin
            if (!c2)
               m = port_cfg_pkg::MODE_PERIPH_PP;
            else if (analog)
               m = port_cfg_pkg::MODE_ANALOG;
            else
               m = port_cfg_pkg::MODE_PERIPH_BIDIR;
         end
      endcase
      return m;
   endfunction : pin_mode

   logic [8:0] wr_dec;
   logic [8:0] rd_dec;
   assign wr_dec = decode_addr(aw_addr);
   assign rd_dec = decode_addr(s_axi_araddr);

   logic       do_write;
   logic [6:0] wr_base;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_base  = 7'({wr_dec[7:4], 3'h0});

   ////////////////////////////////////////////////////////////////////////////
   // axi write address and data, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_held       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held       <= 1'b0;
         w_byte       <= 8'h00;
         w_lane0      <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held       <= 1'b1;
         w_byte       <= s_axi_wdata[7:0];
         w_lane0      <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_held       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= port_cfg_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_dec[8] ? port_cfg_pkg::RESP_OKAY
                                   : port_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration planes, byte lane zero only; pin level is read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_cfg_bit_two  <= port_cfg_pkg::RST_CFG_TWO;
         pin_cfg_bit_one  <= port_cfg_pkg::RST_CFG_ONE;
         pin_cfg_bit_zero <= port_cfg_pkg::RST_CFG_ZERO;
         data_out         <= port_cfg_pkg::RST_DATA_OUT;
      end else if (do_write && wr_dec[8] && w_lane0) begin
         case (4'(wr_dec[3:1]))
            port_cfg_pkg::REG_CFG_TWO:  pin_cfg_bit_two[wr_base +: 8]  <= w_byte;
            port_cfg_pkg::REG_CFG_ONE:  pin_cfg_bit_one[wr_base +: 8]  <= w_byte;
            port_cfg_pkg::REG_CFG_ZERO: pin_cfg_bit_zero[wr_base +: 8] <= w_byte;
            port_cfg_pkg::REG_DATA_OUT: data_out[wr_base +: 8]         <= w_byte;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi read, one outstanding
   logic [7:0] rd_byte;
   logic [6:0] rd_base;
   assign rd_base = 7'({rd_dec[7:4], 3'h0});

   always_comb begin
      case (4'(rd_dec[3:1]))
         port_cfg_pkg::REG_CFG_TWO:  rd_byte = pin_cfg_bit_two[rd_base +: 8];
         port_cfg_pkg::REG_CFG_ONE:  rd_byte = pin_cfg_bit_one[rd_base +: 8];
         port_cfg_pkg::REG_CFG_ZERO: rd_byte = pin_cfg_bit_zero[rd_base +: 8];
         port_cfg_pkg::REG_DATA_OUT: rd_byte = data_out[rd_base +: 8];
         port_cfg_pkg::REG_PIN_LVL:  rd_byte = pin_level[rd_base +: 8];
         default:                    rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= port_cfg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_dec[8] ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         s_axi_rresp   <= rd_dec[8] ? port_cfg_pkg::RESP_OKAY
                                    : port_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-pin drive, pull-up, threshold and routing
   logic [NP-1:0] alt_out;
   logic [NP-1:0] alt_oe;
   // port zero is the multiplexed address/data byte, port one the high address
   assign alt_out = {peripheral_function_out, mem_addr_high,
                     mem_addr_data_out};
   assign alt_oe  = {peripheral_function_oe, 8'hff,
                     {8{mem_addr_data_oe}}};

   logic [NP-1:0] next_pad_out;
   logic [NP-1:0] next_pad_oe;
   logic [NP-1:0] next_pullup;
   logic [NP-1:0] next_cmos;
   logic [NP-1:0] next_analog;
   logic [NP-1:0] next_digital;

   always_comb begin
      port_cfg_pkg::pin_mode_t m;
      logic drive;
      logic level;
      logic pushpull;
      m        = port_cfg_pkg::MODE_INPUT;
      drive    = 1'b0;
      level    = 1'b0;
      pushpull = 1'b0;
      for (int i = 0; i < NP; i++) begin
         m = pin_mode(pin_cfg_bit_two[i], pin_cfg_bit_one[i],
                      pin_cfg_bit_zero[i], port_cfg_pkg::ANALOG_CAPABLE[i]);
         drive    = 1'b0;
         level    = 1'b0;
         pushpull = 1'b0;
         next_analog[i]  = 1'b0;
         next_digital[i] = 1'b1;
         next_pullup[i]  = 1'b0;
         case (m)
            port_cfg_pkg::MODE_BIDIR_OD: begin
               drive          = 1'b1;
               level          = data_out[i];
               next_pullup[i] = 1'b1;
            end
            port_cfg_pkg::MODE_INPUT: ;
            port_cfg_pkg::MODE_OUT_PP: begin
               drive    = 1'b1;
               level    = data_out[i];
               pushpull = 1'b1;
            end
            port_cfg_pkg::MODE_OUT_OD: begin
               drive = 1'b1;
               level = data_out[i];
            end
            port_cfg_pkg::MODE_PERIPH_PP: begin
               drive    = 1'b1;
               level    = alt_out[i];
               pushpull = 1'b1;
            end
            port_cfg_pkg::MODE_PERIPH_BIDIR: begin
               drive    = alt_oe[i];
               level    = alt_out[i];
               pushpull = 1'b1;
            end
            port_cfg_pkg::MODE_ANALOG: begin
               next_analog[i]  = 1'b1;
               next_digital[i] = 1'b0;
            end
            default: ;
         endcase
         // pure open-drain cells have no high-side driver at all
         if (port_cfg_pkg::PURE_OPEN_DRAIN[i])
            pushpull = 1'b0;
         // open drain: low is driven, high releases the pin
         next_pad_out[i] = pushpull ? level : 1'b0;
         next_pad_oe[i]  = drive && (pushpull || !level);
         next_pullup[i]  = next_pullup[i]
                           && port_cfg_pkg::PULLUP_PRESENT[i];
         next_cmos[i]    = pin_cfg_bit_two[i]
                           && !port_cfg_pkg::HYSTERESIS_PIN[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered pad controls and input paths
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_out        <= '0;
         pad_oe         <= '0;
         weak_pullup    <= '0;
         cmos_level_sel <= '0;
         analog_connect <= '0;
      end else begin
         pad_out        <= next_pad_out;
         pad_oe         <= next_pad_oe;
         weak_pullup    <= next_pullup;
         cmos_level_sel <= next_cmos;
         analog_connect <= next_analog;
      end
   end

   // peripheral inputs follow the pin in every digital mode, so enabling
   // the peripheral is all it takes; the pin level is one clock late
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_level              <= '0;
         peripheral_function_in <= '0;
      end else begin
         pin_level              <= pad_in & next_digital;
         peripheral_function_in <= pad_in & next_digital;
      end
   end

endmodule : port_pin_configuration

// *** port_cfg_pkg.sv ***
// constants shared by the port pin configuration block
package port_cfg_pkg;

   localparam int PORT_COUNT = 10;
   localparam int PIN_COUNT  = PORT_COUNT * 8;

   ////////////////////////////////////////////////////////////////////////////
   // register map: one 0x20 window per port, one word per register
   localparam logic [3:0] REG_CFG_ZERO = 4'h0; // offset 0x00
   localparam logic [3:0] REG_CFG_ONE  = 4'h1; // offset 0x04
   localparam logic [3:0] REG_CFG_TWO  = 4'h2; // offset 0x08
   localparam logic [3:0] REG_DATA_OUT = 4'h3; // offset 0x0c
   localparam logic [3:0] REG_PIN_LVL  = 4'h4; // offset 0x10, read only
   localparam int         PORT_SHIFT   = 5;
   localparam int         WORD_SHIFT   = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // per-pin hardware traits, port 9 in the top byte, port 0 in the low byte
   localparam logic [PIN_COUNT-1:0] PULLUP_PRESENT =
      80'hff_ff_ff_ff_08_2e_ff_f3_00_00;
   localparam logic [PIN_COUNT-1:0] HYSTERESIS_PIN =
      80'hff_ff_ff_ff_f7_d9_f6_33_00_00;
   localparam logic [PIN_COUNT-1:0] PURE_OPEN_DRAIN =
      80'h00_00_00_00_00_c0_00_0c_00_00;
   localparam logic [PIN_COUNT-1:0] ANALOG_CAPABLE =
      80'h00_00_ff_00_00_00_00_00_00_00;
   localparam logic [PIN_COUNT-1:0] RESET_BIDIR =
      80'hff_fc_00_00_00_02_00_00_ff_ff;

   ////////////////////////////////////////////////////////////////////////////
   // reset values of the configuration planes and the output data
   localparam logic [PIN_COUNT-1:0] RST_CFG_TWO  = ~RESET_BIDIR;
   localparam logic [PIN_COUNT-1:0] RST_CFG_ONE  = '0;
   localparam logic [PIN_COUNT-1:0] RST_CFG_ZERO = ~RESET_BIDIR;
   localparam logic [PIN_COUNT-1:0] RST_DATA_OUT = '1;

   // pin modes decoded from {cfg two, cfg one, cfg zero}
   typedef enum logic [2:0] {
      MODE_BIDIR_OD,
      MODE_INPUT,
      MODE_OUT_PP,
      MODE_OUT_OD,
      MODE_PERIPH_PP,
      MODE_PERIPH_BIDIR,
      MODE_ANALOG
   } pin_mode_t;

endpackage : port_cfg_pkg

// *** port_pin_configuration_chk.sv ***
// concurrent checks on the ports of the pin configuration block
`timescale 1ns/1ps

module port_pin_configuration_chk #(
   parameter int N = port_cfg_pkg::PIN_COUNT
) (
   // clock and reset
   input wire logic         aclk,
   input wire logic         aresetn,
   // register bus write side
   input wire logic         s_axi_awvalid,
   input wire logic         s_axi_awready,
   input wire logic         s_axi_wvalid,
   input wire logic         s_axi_wready,
   input wire logic         s_axi_bvalid,
   input wire logic         s_axi_bready,
   // pads
   input wire logic [N-1:0] pad_in,
   input wire logic [N-1:0] pad_out,
   input wire logic [N-1:0] pad_oe,
   input wire logic [N-1:0] weak_pullup,
   input wire logic [N-1:0] cmos_level_sel,
   input wire logic [N-1:0] analog_connect,
   input wire logic [N-1:0] peripheral_function_in
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_pure_od_push: assert property (
      (pad_oe & pad_out & port_cfg_pkg::PURE_OPEN_DRAIN) == '0)
      else $error("pure open-drain pin driven high");
   a_pullup_absent: assert property (
      (weak_pullup & ~port_cfg_pkg::PULLUP_PRESENT) == '0)
      else $error("pull-up on a pin without one");
   a_hyst_ignored: assert property (
      (cmos_level_sel & port_cfg_pkg::HYSTERESIS_PIN) == '0)
      else $error("threshold select on a hysteresis pin");
   a_analog_pins: assert property (
      (analog_connect & ~port_cfg_pkg::ANALOG_CAPABLE) == '0)
      else $error("converter on a digital-only pin");
   // analog pins excluded: their input path is masked by the mode
   a_periph_input: assert property (
      $past(aresetn, 2) |-> ((peripheral_function_in ^ $past(pad_in))
         & ~port_cfg_pkg::ANALOG_CAPABLE) == '0)
      else $error("peripheral input does not follow the pin");
   a_reset_mode: assert property (
      $rose(aresetn) |-> ##2 (pad_oe == '0 && weak_pullup ==
         (port_cfg_pkg::RESET_BIDIR & port_cfg_pkg::PULLUP_PRESENT)))
      else $error("pads not in reset mode");
   a_write_resp: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
   a_bresp_done: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
      && s_axi_wready) else $error("write channel not freed");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_od_low: cover property (|(pad_oe & ~pad_out));
   c_analog: cover property (|analog_connect);
endmodule : port_pin_configuration_chk

bind port_pin_configuration port_pin_configuration_chk chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .pad_in, .pad_out,
   .pad_oe, .weak_pullup, .cmos_level_sel, .analog_connect,
   .peripheral_function_in
);

// *** board_model.sv ***
// board side of the pads: block drivers, board drivers and pull-ups
`timescale 1ns/1ps

module board_model (
   // clock
   input  wire logic        aclk,
   // block side
   input  wire logic [79:0] pad_out,
   input  wire logic [79:0] pad_oe,
   input  wire logic [79:0] weak_pullup,
   // board side
   input  wire logic [79:0] ext_level,
   input  wire logic [79:0] ext_en,
   output      logic [79:0] pad_in
);
   logic flip = 1'b0;

   // a floating pin without pull-up toggles, so no test can lean on it
   always_ff @(posedge aclk) begin
      flip <= ~flip;
   end

   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_level)
                 | (~pad_oe & ~ext_en & (weak_pullup | {80{flip}}));
endmodule : board_model

// *** test_port_pin_configuration.sv ***
// self-checking bench for the port pin configuration block
`timescale 1ns/1ps

module test_port_pin_configuration;
   localparam logic [3:0] ZERO = port_cfg_pkg::REG_CFG_ZERO;
   localparam logic [3:0] DOUT = port_cfg_pkg::REG_DATA_OUT;
   localparam logic [1:0] OK = port_cfg_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = port_cfg_pkg::RESP_SLVERR;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, mem_addr_data_oe;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [79:0] pad_in, pad_out, pad_oe, weak_pullup, cmos_level_sel;
   logic [79:0] analog_connect, peripheral_function_in, ext_level, ext_en;
   logic [7:0]  mem_addr_data_out, mem_addr_high;
   logic [63:0] peripheral_function_out, peripheral_function_oe;
   int          err_count, samples_checked;

   port_pin_configuration dut (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pad_in,
      .pad_out, .pad_oe, .weak_pullup, .cmos_level_sel, .analog_connect,
      .mem_addr_data_out, .mem_addr_data_oe, .mem_addr_high,
      .peripheral_function_out, .peripheral_function_oe,
      .peripheral_function_in
   );

   board_model board (
      .aclk, .pad_out, .pad_oe, .weak_pullup, .ext_level, .ext_en, .pad_in
   );

   always #2.5 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   function automatic logic [11:0] adr(input int p, input logic [3:0] r);
      return 12'(p * 32) + {6'h0, r, 2'h0};
   endfunction : adr

   task automatic settle;
      repeat (3) @(posedge aclk);
      #1;
   endtask : settle

   task automatic wr(input int p, input logic [3:0] r, input logic [7:0] d,
                     input logic [1:0] er);
      logic aw, w, b;
      int   n;
      {aw, w, b} = 3'h7;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= adr(p, r);
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (b && n < 50) begin
         @(posedge aclk);
         n++;
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid === 1'b1) begin
            b = 1'b0;
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, er);
         end
      end
      chk(b, 1'b0);
   endtask : wr

   task automatic rd(input int p, input logic [3:0] r, input logic [7:0] ed,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= adr(p, r);
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'b1) begin
            s_axi_arvalid <= 1'b0;
         end
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h0, ed});
      chk(s_axi_rresp, er);
   endtask : rd

   task automatic cfg(input int p, input logic [7:0] two, one, zero);
      wr(p, port_cfg_pkg::REG_CFG_TWO, two, OK);
      wr(p, port_cfg_pkg::REG_CFG_ONE, one, OK);
      wr(p, ZERO, zero, OK);
      wr(p, DOUT, 8'h00, OK);
      settle();
   endtask : cfg

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      settle();
      chk(pad_oe, '0);
      chk(weak_pullup, 80'hff_fc_00_00_00_02_00_00_00_00);
      chk(cmos_level_sel, 80'h00_00_00_00_08_24_09_cc_00_00);
      chk(analog_connect, '0);
      rd(4, port_cfg_pkg::REG_CFG_TWO, 8'hfd, OK);
      rd(8, ZERO, 8'h03, OK);
      rd(0, DOUT, 8'hff, OK);
      // bidirectional open drain pulls low where the data bit is zero
      wr(0, DOUT, 8'h0f, OK);
      settle();
      chk(pad_oe[7:0], 8'hf0);
      $display("reset test done");
   endtask : t_reset

   task automatic t_pins;
      @(posedge aclk);
      ext_level[31:24] <= 8'h5a;
      ext_en[31:24] <= 8'hf7;
      cfg(3, 8'hf7, 8'h08, 8'hf7);
      wr(3, DOUT, 8'h08, OK);
      settle();
      chk(pad_oe[31:24], 8'h08);
      chk(pad_out[27], 1'b1);
      rd(3, port_cfg_pkg::REG_PIN_LVL, 8'h5a, OK);
      cfg(3, 8'hff, 8'h08, 8'hf7);
      chk(pad_oe[27:26], 2'b10);
      chk(pad_out[27], 1'b0);
      wr(3, DOUT, 8'h08, OK);
      settle();
      chk(pad_oe[27], 1'b0);
      cfg(2, 8'hfb, 8'h04, 8'hfb);
      chk(pad_oe[23:16], 8'h04);
      wr(2, DOUT, 8'h04, OK);
      settle();
      chk(pad_oe[23:16], 8'h00);
      cfg(2, 8'h00, 8'h00, 8'hff);
      chk(cmos_level_sel[23:16], 8'h00);
      cfg(2, 8'hff, 8'h00, 8'hff);
      chk(cmos_level_sel[23:16], 8'hcc);
      $display("pin mode test done");
   endtask : t_pins

   // one function per pin: 5.3 output only, 5.2 input only
   task automatic t_periph;
      @(posedge aclk);
      {peripheral_function_out[27], peripheral_function_oe[27]} <= 2'h3;
      {ext_en[42], ext_level[42]} <= 2'h3;
      settle();
      chk(pad_oe[43], 1'b0);
      chk(peripheral_function_in[42], 1'b1);
      cfg(5, 8'hf7, 8'h08, 8'hff);
      chk({pad_oe[43], pad_out[43]}, 2'b11);
      @(posedge aclk);
      peripheral_function_out[27] <= 1'b0;
      ext_level[42] <= 1'b0;
      settle();
      chk(pad_out[43], 1'b0);
      chk(peripheral_function_in[42], 1'b0);
      $display("peripheral test done");
   endtask : t_periph

   task automatic t_bus_analog;
      @(posedge aclk);
      {mem_addr_high, mem_addr_data_out, mem_addr_data_oe} <=
         {8'h3c, 8'ha5, 1'b1};
      {ext_level[63:56], ext_en[63:56]} <= 16'h0303;
      cfg(0, 8'hff, 8'hff, 8'hff);
      cfg(1, 8'hff, 8'hff, 8'hff);
      chk(pad_out[15:0], 16'h3ca5);
      chk(pad_oe[15:0], 16'hffff);
      @(posedge aclk);
      mem_addr_data_oe <= 1'b0;
      settle();
      chk(pad_oe[15:0], 16'hff00);
      cfg(7, 8'h01, 8'h01, 8'hff);
      chk(analog_connect, {16'h0, 8'h01, 56'h0});
      chk(peripheral_function_in[57:56], 2'b10);
      wr(10, ZERO, 8'h55, ERR);
      rd(10, ZERO, 8'h00, ERR);
      rd(2, ZERO, 8'hff, OK);
      $display("bus and analog test done");
   endtask : t_bus_analog

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {mem_addr_data_out, mem_addr_high, mem_addr_data_oe} = '0;
      {peripheral_function_out, peripheral_function_oe} = '0;
      {ext_level, ext_en} = '0;
      err_count = 0;
      samples_checked = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_pins();
      t_periph();
      t_bus_analog();
      wrap_up();
   end

   // the tests need some 250 cycles; this allows eighty times that
   initial begin
      #100000;
      err_count++;
      wrap_up();
   end
endmodule : test_port_pin_configuration
